// [ctb_top.sv]
// Per-buffer transmit control and status with APB register access.
// Assumes an external engine that sends frames, reports outcomes and remote hits.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module ctb_top
    import ctb_pkg::*;
(
    input  wire logic                     I_CLK,
    input  wire logic                     I_NRST,
    input  wire logic                     I_PSEL,
    input  wire logic                     I_PENABLE,
    input  wire logic                     I_PWRITE,
    input  wire logic [ctb_pkg::ADDR_W-1:0]    I_PADDR,
    input  wire logic [ctb_pkg::DATA_W-1:0]    I_PWDATA,
    input  wire logic [3:0]               I_PSTRB,
    output logic      [ctb_pkg::DATA_W-1:0]    O_PRDATA,
    output logic                          O_PREADY,
    output logic                          O_PSLVERR,
    input  wire logic                     I_TX_BUSY,
    input  wire logic                     I_TX_DONE,
    input  wire logic [ctb_pkg::BUF_IDX_W-1:0] I_TX_BUF,
    input  wire logic [1:0]               I_TX_RES,
    input  wire logic                     I_RTR_HIT,
    input  wire logic [ctb_pkg::BUF_IDX_W-1:0] I_RTR_BUF,
    output logic                          O_TX_REQ_VALID,
    output logic      [ctb_pkg::BUF_IDX_W-1:0] O_TX_REQ_BUF,
    output logic      [ctb_pkg::NUM_BUF-1:0]   O_ABORT_REQ,
    output logic                          O_IRQ
);
    import ctb_pkg::*;

    logic [NUM_BUF-1:0]      role_reg, role_next;
    logic [NUM_BUF-1:0]      abt_reg, abt_next;
    logic [NUM_BUF-1:0]      arb_reg, arb_next;
    logic [NUM_BUF-1:0]      err_reg, err_next;
    logic [NUM_BUF-1:0]      sreq_reg, sreq_next;
    logic [NUM_BUF-1:0]      rtr_reg, rtr_next;
    logic [NUM_BUF-1:0]      apend_reg, apend_next;
    logic [1:0]              pri_reg [NUM_BUF];
    logic [1:0]              pri_next [NUM_BUF];
    logic [4*NUM_BUF-1:0]    ist_reg, ist_next;
    logic [4*NUM_BUF-1:0]    ien_reg, ien_next;
    logic [DATA_W-1:0]       rd_reg, rd_next;
    logic                    slverr_reg, slverr_next;
    logic                    txv_reg, txv_next;
    logic [BUF_IDX_W-1:0]    txb_reg, txb_next;

    logic                    setup;
    logic                    wr_acc;
    logic [NUM_CTRL-1:0]     ctrl_hit;
    logic                    hit_ist;
    logic                    hit_ien;
    logic                    hit_iclr;
    logic                    mapped;

    // Read view of one control byte; status bits are read-only
    function automatic logic [7:0] ctrl_byte(input int n);
        ctrl_byte = {role_reg[n], abt_reg[n], arb_reg[n], err_reg[n],
                     sreq_reg[n], rtr_reg[n], pri_reg[n]};
    endfunction

    // Byte lane of the write data that belongs to buffer n
    function automatic logic [7:0] wr_byte(input int n);
        wr_byte = I_PWDATA[(n % 2) * BYTE_W +: BYTE_W];
    endfunction

    // Zero-wait slave: answer is ready in the first access cycle
    assign setup    = I_PSEL & ~I_PENABLE;
    assign wr_acc   = I_PSEL & I_PENABLE & I_PWRITE;
    assign O_PREADY = I_PSEL & I_PENABLE;
    assign O_PRDATA = rd_reg;
    assign O_PSLVERR = slverr_reg & I_PSEL & I_PENABLE;

    // Address decode; an unmapped offset answers with an error
    always_comb begin
        ctrl_hit = '0;
        hit_ist  = 1'b0;
        hit_ien  = 1'b0;
        hit_iclr = 1'b0;
        if (I_PADDR == OFS_CTRL0) begin
            ctrl_hit[0] = 1'b1;
        end else if (I_PADDR == OFS_CTRL1) begin
            ctrl_hit[1] = 1'b1;
        end else if (I_PADDR == OFS_CTRL2) begin
            ctrl_hit[2] = 1'b1;
        end else if (I_PADDR == OFS_CTRL3) begin
            ctrl_hit[3] = 1'b1;
        end else if (I_PADDR == OFS_ISTAT) begin
            hit_ist = 1'b1;
        end else if (I_PADDR == OFS_IEN) begin
            hit_ien = 1'b1;
        end else if (I_PADDR == OFS_ICLR) begin
            hit_iclr = 1'b1;
        end
        mapped = (|ctrl_hit) | hit_ist | hit_ien | hit_iclr;
    end

    // Per-buffer control, flags and selection in one pass over all buffers
    always_comb begin
        logic               bwr;
        logic               done_n;
        logic               act_n;
        logic               sw_set;
        logic               sw_abt;
        logic               rtr_set;
        logic               req_set;
        logic [7:0]         wb;
        logic [NUM_BUF-1:0] ev_ok, ev_abt, ev_arb, ev_err;
        logic [1:0]         best_pri;
        logic               found;
        bwr     = 1'b0;
        done_n  = 1'b0;
        act_n   = 1'b0;
        sw_set  = 1'b0;
        sw_abt  = 1'b0;
        rtr_set = 1'b0;
        req_set = 1'b0;
        wb      = RESET_BYTE;
        ev_ok   = '0;
        ev_abt  = '0;
        ev_arb  = '0;
        ev_err  = '0;
        best_pri = 2'h0;
        found   = 1'b0;
        role_next  = role_reg;
        abt_next   = abt_reg;
        arb_next   = arb_reg;
        err_next   = err_reg;
        sreq_next  = sreq_reg;
        rtr_next   = rtr_reg;
        apend_next = apend_reg;
        ien_next   = ien_reg;
        txv_next   = 1'b0;
        txb_next   = txb_reg;
        for (int n = 0; n < NUM_BUF; n++) begin
            pri_next[n] = pri_reg[n];
            // Upper byte of the low half-word drives the odd buffer
            bwr = wr_acc & ctrl_hit[n / 2] & I_PSTRB[n % 2];
            wb  = wr_byte(n);
            done_n  = I_TX_DONE & (I_TX_BUF == BUF_IDX_W'(n));
            act_n   = I_TX_BUSY & (I_TX_BUF == BUF_IDX_W'(n));
            sw_set  = bwr & wb[SREQ_BIT] & ~sreq_reg[n];
            sw_abt  = bwr & ~wb[SREQ_BIT] & sreq_reg[n];
            rtr_set = I_RTR_HIT & (I_RTR_BUF == BUF_IDX_W'(n)) & rtr_reg[n]
                      & ~sreq_reg[n];
            req_set = sw_set | rtr_set;
            if (bwr) begin
                role_next[n] = wb[ROLE_BIT];
                rtr_next[n]  = wb[RTR_BIT];
                pri_next[n]  = wb[PRI_HI:PRI_LO];
            end
            // Flags clear on a new request; an outcome in the same cycle wins
            if (req_set) begin
                abt_next[n] = 1'b0;
                arb_next[n] = 1'b0;
                err_next[n] = 1'b0;
                sreq_next[n] = 1'b1;
            end else if (sw_abt) begin
                sreq_next[n] = 1'b0;
                if (act_n && !done_n) begin
                    apend_next[n] = 1'b1;
                end else begin
                    ev_abt[n] = 1'b1;
                end
            end
            // Engine may start from a stale offer; cancel a send nobody asked for
            if (act_n && !done_n && !(sreq_reg[n] && role_reg[n])) begin
                apend_next[n] = 1'b1;
            end
            if (done_n) begin
                apend_next[n] = 1'b0;
                case (ctb_res_e'(I_TX_RES))
                    RES_OK: begin
                        ev_ok[n] = 1'b1;
                        abt_next[n] = 1'b0;
                        sreq_next[n] = req_set;
                    end
                    RES_ARB: begin
                        ev_arb[n] = 1'b1;
                        ev_abt[n] = ev_abt[n] | apend_reg[n];
                    end
                    RES_ERR: begin
                        ev_err[n] = 1'b1;
                        ev_abt[n] = ev_abt[n] | apend_reg[n];
                    end
                    default: begin
                        ev_abt[n] = 1'b1;
                        // A request made while the abort was pending survives
                        sreq_next[n] = req_set | (sreq_reg[n] & apend_reg[n]);
                    end
                endcase
            end
            // Outcome events are applied last, so they win over a clear
            if (ev_abt[n]) begin
                abt_next[n] = 1'b1;
            end
            if (ev_arb[n]) begin
                arb_next[n] = 1'b1;
            end
            if (ev_err[n]) begin
                err_next[n] = 1'b1;
            end
            // Highest priority wins, lowest index breaks ties
            // Receive-role buffers never offered to the engine
            if (sreq_reg[n] && role_reg[n] && !apend_reg[n]
                && (!found || pri_reg[n] > best_pri)) begin
                found    = 1'b1;
                best_pri = pri_reg[n];
                txb_next = BUF_IDX_W'(n);
            end
        end
        txv_next = found;
        // Enable mask has the status layout; byte strobes are ignored here
        if (wr_acc && hit_ien) begin
            ien_next = I_PWDATA[4*NUM_BUF-1:0];
        end
        // Event set wins over a same-cycle clear
        ist_next = ist_reg;
        if (wr_acc && hit_iclr) begin
            ist_next = ist_reg & ~I_PWDATA[4*NUM_BUF-1:0];
        end
        ist_next = ist_next | {ev_err, ev_arb, ev_abt, ev_ok};
        // Read data is captured in the setup cycle
        rd_next     = rd_reg;
        slverr_next = 1'b0;
        if (setup) begin
            rd_next     = '0;
            slverr_next = ~mapped;
            for (int k = 0; k < NUM_CTRL; k++) begin
                if (ctrl_hit[k]) begin
                    rd_next[HALF_W-1:0] = {ctrl_byte(2 * k + 1), ctrl_byte(2 * k)};
                end
            end
            if (hit_ist) begin
                rd_next[4*NUM_BUF-1:0] = ist_reg;
            end else if (hit_ien) begin
                rd_next[4*NUM_BUF-1:0] = ien_reg;
            end
        end
    end

    // Register stage only; next values come from the processes above
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            role_reg   <= '0;
            abt_reg    <= '0;
            arb_reg    <= '0;
            err_reg    <= '0;
            sreq_reg   <= '0;
            rtr_reg    <= '0;
            apend_reg  <= '0;
            for (int n = 0; n < NUM_BUF; n++) begin
                pri_reg[n] <= 2'h0;
            end
            ist_reg    <= '0;
            ien_reg    <= '0;
            rd_reg     <= '0;
            slverr_reg <= 1'b0;
            txv_reg    <= 1'b0;
            txb_reg    <= '0;
        end else begin
            role_reg   <= role_next;
            abt_reg    <= abt_next;
            arb_reg    <= arb_next;
            err_reg    <= err_next;
            sreq_reg   <= sreq_next;
            rtr_reg    <= rtr_next;
            apend_reg  <= apend_next;
            for (int n = 0; n < NUM_BUF; n++) begin
                pri_reg[n] <= pri_next[n];
            end
            ist_reg    <= ist_next;
            ien_reg    <= ien_next;
            rd_reg     <= rd_next;
            slverr_reg <= slverr_next;
            txv_reg    <= txv_next;
            txb_reg    <= txb_next;
        end
    end

    // Selection lags the registers by one cycle; a stale start gets an abort
    // Abort request stays up until the engine reports that buffer's outcome
    assign O_TX_REQ_VALID = txv_reg;
    assign O_TX_REQ_BUF   = txb_reg;
    assign O_ABORT_REQ    = apend_reg;
    assign O_IRQ          = |(ist_reg & ien_reg);

endmodule

`default_nettype wire

// [ctb_pkg.sv]
// Constants for the transmit buffer control block.
// Assumes a 32-bit APB bus and an external CAN arbitration engine.
package ctb_pkg;
    localparam int          NUM_BUF    = 8;
    localparam int          BUF_IDX_W  = 3;
    localparam int          NUM_CTRL   = NUM_BUF / 2;
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL0  = 8'h00;
    localparam logic [7:0]  OFS_CTRL1  = 8'h04;
    localparam logic [7:0]  OFS_CTRL2  = 8'h08;
    localparam logic [7:0]  OFS_CTRL3  = 8'h0C;
    localparam logic [7:0]  OFS_ISTAT  = 8'h10;
    localparam logic [7:0]  OFS_IEN    = 8'h14;
    localparam logic [7:0]  OFS_ICLR   = 8'h18;
    // Control byte fields
    localparam int          ROLE_BIT   = 7;
    localparam int          ABT_BIT    = 6;
    localparam int          ARB_BIT    = 5;
    localparam int          ERR_BIT    = 4;
    localparam int          SREQ_BIT   = 3;
    localparam int          RTR_BIT    = 2;
    localparam int          PRI_HI     = 1;
    localparam int          PRI_LO     = 0;
    localparam int          BYTE_W     = 8;
    localparam int          HALF_W     = 16;
    // Interrupt status lanes, NUM_BUF bits each
    localparam int          EV_OK      = 0;
    localparam int          EV_ABT     = 1;
    localparam int          EV_ARB     = 2;
    localparam int          EV_ERR     = 3;
    localparam logic [7:0]  RESET_BYTE = 8'h00;
    // Outcome codes from the arbitration engine
    typedef enum logic [1:0] {
        RES_OK  = 2'h0,
        RES_ARB = 2'h1,
        RES_ERR = 2'h2,
        RES_ABT = 2'h3
    } ctb_res_e;
endpackage

// [ctb_chk_sva.sv]
// Port assertions for the transmit buffer control block.
// Assumes the engine spaces outcomes and software aborts apart.
`timescale 1ns/10ps
`default_nettype none
module ctb_chk
    import ctb_pkg::*;
(
    input wire logic       I_CLK,
    input wire logic       I_NRST,
    input wire logic       I_PSEL,
    input wire logic       I_PENABLE,
    input wire logic       I_PWRITE,
    input wire logic       O_PREADY,
    input wire logic       O_PSLVERR,
    input wire logic       I_TX_BUSY,
    input wire logic       I_TX_DONE,
    input wire logic [2:0] I_TX_BUF,
    input wire logic [1:0] I_TX_RES,
    input wire logic       I_RTR_HIT,
    input wire logic       O_TX_REQ_VALID,
    input wire logic [2:0] O_TX_REQ_BUF,
    input wire logic [7:0] O_ABORT_REQ
);
    import ctb_pkg::*;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    a_ready_zero_wait: assert property (I_PSEL && I_PENABLE |-> O_PREADY)
        else $error("pready missing in access");
    a_err_in_access: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
        else $error("pslverr outside access");
    a_ok_retires: assert property (I_TX_DONE && I_TX_RES == RES_OK |-> ##2
        !(O_TX_REQ_VALID && O_TX_REQ_BUF == $past(I_TX_BUF, 2)))
        else $error("sent buffer still requested");
    a_arb_retry: assert property (I_TX_DONE && I_TX_RES == RES_ARB |-> ##2 O_TX_REQ_VALID)
        else $error("lost buffer not retried");
    a_err_retry: assert property (I_TX_DONE && I_TX_RES == RES_ERR |-> ##2 O_TX_REQ_VALID)
        else $error("errored buffer not retried");
    a_abort_ends: assert property (I_TX_DONE |=> !O_ABORT_REQ[$past(I_TX_BUF)])
        else $error("abort request outlives done");
    a_abort_in_flight: assert property ($rose(|O_ABORT_REQ) |->
        $past(I_TX_BUSY) && O_ABORT_REQ == 8'h01 << $past(I_TX_BUF))
        else $error("abort request for idle buffer");
    a_req_has_cause: assert property ($rose(O_TX_REQ_VALID) |->
        $past(I_PSEL && I_PENABLE && I_PWRITE, 2) || $past(I_RTR_HIT, 2) || $past(I_TX_DONE, 2))
        else $error("request without cause");
endmodule
bind ctb_top ctb_chk i_chk (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_TX_BUSY(I_TX_BUSY), .I_TX_DONE(I_TX_DONE),
    .I_TX_BUF(I_TX_BUF), .I_TX_RES(I_TX_RES), .I_RTR_HIT(I_RTR_HIT),
    .O_TX_REQ_VALID(O_TX_REQ_VALID), .O_TX_REQ_BUF(O_TX_REQ_BUF), .O_ABORT_REQ(O_ABORT_REQ));
`default_nettype wire

// [ctb_node.sv]
// Bus-side engine model: sends the offered buffer, reports an outcome.
// Assumes the bench picks the outcome and may stall pickup.
`timescale 1ns/10ps
`default_nettype none
module ctb_node
    import ctb_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_stall,
    input  wire logic [1:0] i_res,
    input  wire logic       i_req_v,
    input  wire logic [2:0] i_req_b,
    input  wire logic [7:0] i_abt,
    output logic            o_busy,
    output logic            o_done,
    output logic      [2:0] o_buf,
    output logic      [1:0] o_res
);
    int cnt;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            {o_busy, o_done, o_buf, o_res} <= '0;
            cnt <= 0;
        end else begin
            o_done <= 1'b0;
            if (cnt > 0) cnt <= cnt - 1;
            // Idle index lines toggle so stale values cannot pass
            if (o_done) o_buf <= ~o_buf;
            if (o_busy && (cnt == 1 || i_abt[o_buf])) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
                o_res  <= i_abt[o_buf] ? RES_ABT : i_res;
                cnt    <= 4;
            end else if (!o_busy && cnt == 0 && i_req_v && !i_stall) begin
                o_busy <= 1'b1;
                o_buf  <= i_req_b;
                cnt    <= 12;
            end
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the transmit buffer control block.
// Assumes zero-wait APB and the engine model on the bus side.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ctb_pkg::*;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, stall = 0, hit = 0;
    logic [7:0]  paddr = '0, abt;
    logic [3:0]  pstrb = 4'hF;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic [2:0]  rbuf = '0, tbuf, qbuf;
    logic [1:0]  res = RES_OK, tres;
    logic        pready, perr, rerr, busy, done, qv, irq;
    int          fails = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    ctb_top i_ctb_top (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr), .I_TX_BUSY(busy),
        .I_TX_DONE(done), .I_TX_BUF(tbuf), .I_TX_RES(tres), .I_RTR_HIT(hit),
        .I_RTR_BUF(rbuf), .O_TX_REQ_VALID(qv), .O_TX_REQ_BUF(qbuf),
        .O_ABORT_REQ(abt), .O_IRQ(irq));
    ctb_node i_ctb_node (.i_clk(clk), .i_nrst(nrst), .i_stall(stall), .i_res(res),
        .i_req_v(qv), .i_req_b(qbuf), .i_abt(abt), .o_busy(busy), .o_done(done),
        .o_buf(tbuf), .o_res(tres));
    task conclude;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = perr;
        if (pready !== 1'b1) begin fails++; conclude(); end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task waitst(input int b);
        int n;
        n = 0;
        do begin xfer(0, OFS_ISTAT, 0); n++; end while (rdat[b] !== 1'b1 && n < 60);
        if (rdat[b] !== 1'b1) begin fails++; conclude(); end
    endtask
    // Lets an abort land well inside a send, clear of the stale-offer window
    task waitbusy;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (busy !== 1'b0 && n < 40);
        do begin @(posedge clk); n++; end while (busy !== 1'b1 && n < 40);
        if (busy !== 1'b1) begin fails++; conclude(); end
    endtask
    task pulse;
        @(posedge clk) {hit, rbuf} <= {1'b1, 3'h4};
        @(posedge clk) {hit, rbuf} <= {1'b0, 3'h3};
        xfer(0, OFS_CTRL2, 0);
    endtask
    task s_basic;
        xfer(0, OFS_CTRL0, 0); chk("ctrl0 reset", 0, rdat);
        xfer(0, 8'h1C, 0); chk("unmapped", 1, rerr);
        pstrb <= 4'h2;
        xfer(1, OFS_CTRL0, 32'h0303);
        pstrb <= 4'hF;
        xfer(0, OFS_CTRL0, 0); chk("strobe upper", 32'h0300, rdat);
        xfer(1, OFS_IEN, 32'h1);
        xfer(1, OFS_CTRL0, 32'h88);
        waitst(EV_OK * 8);
        xfer(0, OFS_CTRL0, 0); chk("sent", 32'h80, rdat);
        #1 chk("irq", 1, irq);
        xfer(1, OFS_ICLR, 32'h1);
        #1 chk("irq cleared", 0, irq);
    endtask
    task s_arb_abort;
        res <= RES_ARB;
        xfer(1, OFS_CTRL0, 32'h8880);
        waitst(EV_ARB * 8 + 1);
        xfer(0, OFS_CTRL0, 0); chk("lost", 8'hA8, rdat[15:8]);
        waitbusy();
        xfer(1, OFS_CTRL0, 32'h8080);
        waitst(EV_ABT * 8 + 1);
        xfer(0, OFS_CTRL0, 0); chk("aborted", 2'b10, {rdat[14], rdat[11]});
        res <= RES_OK;
        xfer(1, OFS_CTRL0, 32'h8880);
        xfer(0, OFS_CTRL0, 0); chk("flags cleared", 0, rdat[14:12]);
        waitst(EV_OK * 8 + 1);
        xfer(0, OFS_CTRL0, 0); chk("resent", 32'h8080, rdat);
        #1 chk("irq masked", 0, irq);
    endtask
    task s_err_rx;
        res <= RES_ERR;
        xfer(1, OFS_CTRL1, 32'h88);
        waitst(EV_ERR * 8 + 2);
        xfer(0, OFS_CTRL1, 0); chk("bus error", 8'h98, rdat[7:0]);
        waitbusy();
        xfer(1, OFS_CTRL1, 32'h80);
        waitst(EV_ABT * 8 + 2);
        res <= RES_OK;
        xfer(1, OFS_CTRL1, 32'h0880);
        repeat (10) @(posedge clk);
        #1 chk("rx no frame", 0, qv);
        xfer(1, OFS_CTRL1, 32'h0080);
    endtask
    task s_rtr_prio;
        logic [7:0]  ta [4] = '{OFS_CTRL3, OFS_CTRL3, OFS_CTRL2, OFS_CTRL2};
        logic [31:0] td [4] = '{32'h8A80, 32'h8080, 32'h808C, 32'h8080};
        logic [2:0]  tw [4] = '{3'h6, 3'h7, 3'h5, 3'h4};
        stall <= 1'b1;
        xfer(1, OFS_CTRL2, 32'h80);
        pulse(); chk("remote off", 8'h80, rdat[7:0]);
        xfer(1, OFS_CTRL2, 32'h84);
        pulse(); chk("remote on", 8'h8C, rdat[7:0]);
        xfer(1, OFS_CTRL2, 32'h898C);
        xfer(1, OFS_CTRL3, 32'h8A8B);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1 chk("winner", tw[i], qbuf);
            xfer(1, ta[i], td[i]);
        end
        @(posedge clk);
        #1 chk("none left", 0, qv);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        s_basic();
        s_arb_abort();
        s_err_rx();
        s_rtr_prio();
        conclude();
    end
endmodule
`default_nettype wire
